// >>> mss_start_sync.sv
// Masterless start-line handshake and pipeline advance
`timescale 1ns/10ps
module mss_start_sync (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic busy_en_in,
  input wire logic active_pol_in,
  input wire logic pin_dir_out_in,
  input wire logic timer_expired_in,
  input wire logic [mss_pkg::ADD_W-1:0] start_out_add_in,
  input wire logic [mss_pkg::NDEST-1:0] pipe_en_in,
  input wire logic [mss_pkg::NDEST-1:0] cyclic_en_in,
  input wire logic pipe_wr_en_in,
  input wire logic [mss_pkg::IDX_W-1:0] pipe_wr_idx_in,
  input wire logic [mss_pkg::DATA_W-1:0] pipe_wr_data_in,
  input wire logic start_pin_in,
  output logic start_pin_out,
  output logic start_pin_oe_out,
  output logic start_pin_strong_out,
  output logic internal_start_out,
  output logic busy_out,
  output logic [mss_pkg::DATA_W-1:0] target_position_out,
  output logic [mss_pkg::DATA_W-1:0] compare_position_out,
  output logic [mss_pkg::DATA_W-1:0] follow_ratio_out,
  output logic [mss_pkg::DATA_W-1:0] global_config_out
);
  mss_pkg::mss_state_t state_reg;
  mss_pkg::mss_state_t state_next;
  logic [mss_pkg::ADD_W-1:0] cnt_reg;
  logic [mss_pkg::ADD_W-1:0] cnt_next;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic int_start_reg;
  logic pin_level_reg;
  logic line_active;
  logic start_evt;
  logic plain_mode;

  mss_pipe_if pif ();

  // Pin comes from other devices: two flops before any use
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= start_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign plain_mode = !busy_en_in;
  assign line_active = (pin_sync_reg == active_pol_in);
  // start event
  // Timer expiry only counts in busy state or in plain mode; later expiries are dropped
  assign start_evt = timer_expired_in &&
                     (plain_mode || (state_reg == mss_pkg::MSS_BUSY));

  // Handshake sequencing
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      mss_pkg::MSS_BUSY:
      begin
        if (busy_en_in && timer_expired_in)
          state_next = mss_pkg::MSS_RELEASE;
      end
      mss_pkg::MSS_RELEASE:
      begin
        if (line_active)
        begin
          cnt_next = start_out_add_in;
          if (start_out_add_in != mss_pkg::CNT_ZERO)
            state_next = mss_pkg::MSS_HOLD;
          else
            state_next = mss_pkg::MSS_BUSY;
        end
      end
      mss_pkg::MSS_HOLD:
      begin
        cnt_next = cnt_reg - mss_pkg::CNT_ONE;
        if (cnt_reg == mss_pkg::CNT_ONE)
          state_next = mss_pkg::MSS_BUSY;
      end
    endcase
    if (plain_mode)
      state_next = mss_pkg::MSS_BUSY;
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= mss_pkg::MSS_BUSY;
      cnt_reg <= mss_pkg::CNT_ZERO;
      int_start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      int_start_reg <= start_evt;
    end
  end

  // Plain mode shows each internal start as one active-level cycle
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      pin_level_reg <= 1'b0;
    else
      pin_level_reg <= start_evt;
  end

  // pin drive
  // Weak drive is oe high with strong low; the board resolves it
  always_comb
  begin
    start_pin_oe_out = 1'b1;
    start_pin_strong_out = 1'b1;
    start_pin_out = !active_pol_in;
    if (plain_mode)
    begin
      start_pin_oe_out = pin_dir_out_in;
      start_pin_out = pin_level_reg ? active_pol_in : !active_pol_in;
    end
    else if (state_reg == mss_pkg::MSS_RELEASE)
    begin
      start_pin_strong_out = 1'b0;
      start_pin_out = active_pol_in;
    end
    else if (state_reg == mss_pkg::MSS_HOLD)
      start_pin_out = active_pol_in;
  end

  assign internal_start_out = int_start_reg;
  assign busy_out = busy_en_in && (state_reg == mss_pkg::MSS_BUSY);

  // Pipeline carrier hookup
  assign pif.start_evt = start_evt;
  assign pif.en = pipe_en_in;
  assign pif.cyc = cyclic_en_in;
  assign pif.wr_en = pipe_wr_en_in;
  assign pif.wr_idx = pipe_wr_idx_in;
  assign pif.wr_data = pipe_wr_data_in;

  mss_pipeline u_pipe (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pif(pif)
  );

  assign target_position_out = pif.dest[mss_pkg::DEST_TARGET];
  assign compare_position_out = pif.dest[mss_pkg::DEST_COMPARE];
  assign follow_ratio_out = pif.dest[mss_pkg::DEST_RATIO];
  assign global_config_out = pif.dest[mss_pkg::DEST_CONFIG];

  AST_BUSY_STRONG_INACTIVE: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (busy_en_in && state_reg == mss_pkg::MSS_BUSY) |->
      start_pin_oe_out && start_pin_strong_out &&
      (start_pin_out != active_pol_in))
    else $error("busy state not driving inactive level strongly");

  AST_RELEASE_WEAK: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (busy_en_in && state_reg == mss_pkg::MSS_BUSY && timer_expired_in)
      ##1 busy_en_in |->
      !start_pin_strong_out && (start_pin_out == active_pol_in) &&
      internal_start_out)
    else $error("start did not release the line weakly");

  AST_HOLD_ENTRY: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (state_reg == mss_pkg::MSS_RELEASE && line_active && busy_en_in &&
     start_out_add_in == 8'h03) |=>
      (start_pin_strong_out && start_pin_out == active_pol_in) [*3]
      ##1 (state_reg == mss_pkg::MSS_BUSY))
    else $error("strong active interval has wrong length");

  AST_HOLD_END: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (state_reg == mss_pkg::MSS_HOLD && cnt_reg == 8'h01) |=>
      (state_reg == mss_pkg::MSS_BUSY))
    else $error("hold did not return to busy");

  AST_ZERO_EXTENSION: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (state_reg == mss_pkg::MSS_RELEASE && line_active &&
     start_out_add_in == 8'h00) |=> (state_reg == mss_pkg::MSS_BUSY))
    else $error("zero extension did not skip the hold");

  AST_PLAIN_NO_HANDSHAKE: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !busy_en_in |=> (state_reg == mss_pkg::MSS_BUSY) &&
      (!busy_en_in || start_pin_strong_out))
    else $error("handshake ran with busy-enable cleared");

  AST_PLAIN_DIRECTION: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !busy_en_in |-> (start_pin_oe_out == pin_dir_out_in))
    else $error("plain mode pin direction wrong");
endmodule : mss_start_sync

// >>> mss_pkg.sv
// Constants and types for the masterless start synchroniser
// Operation
// - Busy-enable set to one selects the tristate start handshake mode.
// - Busy state drives the inactive start level strongly as output.
// - Timer expiry raises internal start; pin released, active level driven weakly.
// - Line reads active: drive active strongly for the extension cycle count.
// - After the strong interval return to busy until the next start.
// - Four destinations enabled form four two-stage pipelines, cyclic or not.
// - Each internal start loads enabled destinations from mapped stages, pipes advance.
package mss_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STAGES = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned NDEST = 4;
  localparam int unsigned ADD_W = 8;
  // Destination order follows the pipeline enable bits
  localparam int unsigned DEST_TARGET = 0;
  localparam int unsigned DEST_COMPARE = 1;
  localparam int unsigned DEST_RATIO = 2;
  localparam int unsigned DEST_CONFIG = 3;
  localparam logic [DATA_W-1:0] DEST_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STAGE_RESET = 32'h0000_0000;
  localparam logic [ADD_W-1:0] CNT_ONE = 8'h01;
  localparam logic [ADD_W-1:0] CNT_ZERO = 8'h00;
  // Stage spacing for two, three and four enabled destinations
  localparam logic [IDX_W-1:0] SPAN_TWO = 3'h4;
  localparam logic [IDX_W-1:0] SPAN_THREE = 3'h3;
  localparam logic [IDX_W-1:0] SPAN_FOUR = 3'h2;

  typedef enum logic [1:0] {MSS_BUSY, MSS_RELEASE, MSS_HOLD} mss_state_t;
endpackage : mss_pkg

// >>> mss_pipe_if.sv
// Carrier between the start handshake and the parameter pipelines
`timescale 1ns/10ps
interface mss_pipe_if;
  logic start_evt;
  logic [mss_pkg::NDEST-1:0] en;
  logic [mss_pkg::NDEST-1:0] cyc;
  logic wr_en;
  logic [mss_pkg::IDX_W-1:0] wr_idx;
  logic [mss_pkg::DATA_W-1:0] wr_data;
  logic [mss_pkg::DATA_W-1:0] dest [mss_pkg::NDEST];

  modport ctrl (output start_evt, en, cyc, wr_en, wr_idx, wr_data,
                input dest);
  modport pipe (input start_evt, en, cyc, wr_en, wr_idx, wr_data,
                output dest);
endinterface : mss_pipe_if

// >>> mss_pipeline.sv
// Segmented parameter pipeline with destination registers
`timescale 1ns/10ps
module mss_pipeline (
  input wire logic clk_in,
  input wire logic resetn_in,
  mss_pipe_if.pipe pif
);
  logic [mss_pkg::DATA_W-1:0] stage_reg [mss_pkg::STAGES];
  logic [mss_pkg::DATA_W-1:0] stage_next [mss_pkg::STAGES];
  logic [mss_pkg::DATA_W-1:0] dest_reg [mss_pkg::NDEST];
  logic [1:0] owner [mss_pkg::STAGES];
  logic [mss_pkg::STAGES-1:0] seg_end;

  localparam int unsigned IDX_W = mss_pkg::IDX_W;

  // Head stage of a destination: spacing set by how many are enabled
  function automatic logic [mss_pkg::IDX_W-1:0] head_of(
    input logic [mss_pkg::NDEST-1:0] en, input int unsigned d);
    logic [2:0] cnt;
    logic [2:0] rank;
    logic [mss_pkg::IDX_W-1:0] span;
    cnt = 3'h0;
    rank = 3'h0;
    for (int unsigned k = 0; k < mss_pkg::NDEST; k++)
    begin
      cnt = cnt + {2'h0, en[k]};
      if (k < d)
        rank = rank + {2'h0, en[k]};
    end
    unique case (cnt)
      3'h2: span = mss_pkg::SPAN_TWO;
      3'h3: span = mss_pkg::SPAN_THREE;
      3'h4: span = mss_pkg::SPAN_FOUR;
      default: span = 3'h0;
    endcase
    return IDX_W'(rank * span);
  endfunction : head_of

  // Owner of each stage and end of each segment, from the mapping
  always_comb
  begin
    for (int unsigned i = 0; i < mss_pkg::STAGES; i++)
    begin
      owner[i] = 2'h0;
      seg_end[i] = (i == mss_pkg::STAGES - 1);
      for (int unsigned d = 0; d < mss_pkg::NDEST; d++)
      begin
        if (pif.en[d] && (head_of(pif.en, d) <= IDX_W'(i)))
          owner[i] = 2'(d);
        if (pif.en[d] && (i + 1 < mss_pkg::STAGES) &&
            (head_of(pif.en, d) == IDX_W'(i + 1)))
          seg_end[i] = 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < mss_pkg::STAGES; gi++)
    begin : g_stage
      // shift or rewrite
      // Segment tail takes the outgoing destination when cyclic
      always_comb
      begin
        stage_next[gi] = stage_reg[gi];
        if (pif.start_evt && (pif.en != 4'h0))
        begin
          if (!seg_end[gi])
            stage_next[gi] = stage_reg[(gi + 1) % mss_pkg::STAGES];
          else if (pif.cyc[owner[gi]])
            stage_next[gi] = dest_reg[owner[gi]];
        end
        if (pif.wr_en && (pif.wr_idx == IDX_W'(gi)))
          stage_next[gi] = pif.wr_data;
      end

      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          stage_reg[gi] <= mss_pkg::STAGE_RESET;
        else
          stage_reg[gi] <= stage_next[gi];
      end
    end

    for (gi = 0; gi < mss_pkg::NDEST; gi++)
    begin : g_dest
      always_ff @(posedge clk_in or negedge resetn_in)
      begin
        if (!resetn_in)
          dest_reg[gi] <= mss_pkg::DEST_RESET;
        else if (pif.start_evt && pif.en[gi])
          dest_reg[gi] <= stage_reg[head_of(pif.en, gi)];
      end
      assign pif.dest[gi] = dest_reg[gi];
    end
  endgenerate

  AST_DEST_FROM_HEAD: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (pif.start_evt && pif.en == 4'b1111) |=>
      (dest_reg[2] == $past(stage_reg[4])) &&
      (dest_reg[3] == $past(stage_reg[6])))
    else $error("destination not loaded from its mapped stage");

  AST_FOUR_PIPES_CYCLIC: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (pif.start_evt && pif.en == 4'b1111 && pif.cyc[0] && !pif.wr_en)
      |=> (stage_reg[1] == $past(dest_reg[0])) &&
          (stage_reg[0] == $past(stage_reg[1])))
    else $error("two-stage cyclic pipeline did not rotate");

  AST_SINGLE_SHIFT: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (pif.start_evt && pif.en == 4'b0010 && !pif.wr_en && !pif.cyc[1])
      |=> (stage_reg[0] == $past(stage_reg[1])) &&
          (stage_reg[7] == $past(stage_reg[7])))
    else $error("eight-stage pipeline did not advance");

  AST_QUIET_HOLD: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    (!pif.start_evt && !pif.wr_en) |=>
      $stable(stage_reg[0]) && $stable(dest_reg[0]))
    else $error("pipeline changed without a start");
endmodule : mss_pipeline

// >>> mss_peer_model.sv
// Peer controller model sharing the start line with the block
`timescale 1ns/10ps
module mss_peer_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic pol_in,
  input wire logic [7:0] busy_len_in,
  input wire logic dut_out_in,
  input wire logic dut_oe_in,
  input wire logic dut_strong_in,
  output logic line_out
);
  logic [7:0] cnt_reg;
  logic weak_reg;
  logic dut_weak;
  logic peer_hold;
  // Peer stays busy for a while after our side lets go
  assign dut_weak = dut_oe_in && !dut_strong_in;
  assign peer_hold = (cnt_reg != 8'h00) ||
    (dut_weak && !weak_reg && busy_len_in != 8'h00);
  // line follows our side when driven strongly, else goes active once the peer let go
  assign line_out = (dut_oe_in && dut_strong_in) ? dut_out_in :
    peer_hold ? !pol_in : pol_in;
  // Busy countdown, loaded as our side turns weak
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_reg <= 8'h00;
      weak_reg <= 1'b0;
    end
    else
    begin
      weak_reg <= dut_weak;
      if (dut_weak && !weak_reg)
        cnt_reg <= busy_len_in;
      else if (cnt_reg != 8'h00)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule : mss_peer_model

// >>> masterless_start_sync_tb.sv
// Self-checking bench for the start synchroniser
`timescale 1ns/10ps
module masterless_start_sync_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic busy_en = 1'b1;
  logic pol = 1'b1;
  logic dir = 1'b0;
  logic tmr = 1'b0;
  logic [7:0] add = 8'h02;
  logic [3:0] pen = 4'h1;
  logic [3:0] cyc = 4'h0;
  logic wen = 1'b0;
  logic [2:0] widx = 3'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0] blen = 8'h04;
  logic line, p_out, p_oe, p_str, istart, busy;
  logic [31:0] tgt, cmp, rat, cfg;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [31:0] T0 = 32'h1234_5678;
  // Clock at 100 MHz
  always #5 clk_in = ~clk_in;
  mss_start_sync dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .busy_en_in(busy_en), .active_pol_in(pol), .pin_dir_out_in(dir),
    .timer_expired_in(tmr), .start_out_add_in(add), .pipe_en_in(pen),
    .cyclic_en_in(cyc), .pipe_wr_en_in(wen), .pipe_wr_idx_in(widx),
    .pipe_wr_data_in(wdat), .start_pin_in(line), .start_pin_out(p_out),
    .start_pin_oe_out(p_oe), .start_pin_strong_out(p_str),
    .internal_start_out(istart), .busy_out(busy),
    .target_position_out(tgt), .compare_position_out(cmp),
    .follow_ratio_out(rat), .global_config_out(cfg));
  mss_peer_model peer (.clk_in(clk_in), .resetn_in(resetn_in),
    .pol_in(pol), .busy_len_in(blen), .dut_out_in(p_out),
    .dut_oe_in(p_oe), .dut_strong_in(p_str), .line_out(line));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk32
  // Inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic pulse_timer;
    tmr = 1'b1;
    tick(1);
    tmr = 1'b0;
  endtask : pulse_timer
  task automatic wr_stage(input logic [2:0] i, input logic [31:0] d);
    wen = 1'b1;
    widx = i;
    wdat = d;
    tick(1);
    wen = 1'b0;
  endtask : wr_stage
  task automatic t_reset;
    chk1("oe", 1'b1, p_oe);
    chk1("strong", 1'b1, p_str);
    chk1("out", 1'b0, p_out);
    chk1("busy", 1'b1, busy);
    chk32("target", 32'h0000_0000, tgt);
  endtask : t_reset
  // Full handshake against a slow peer, with a refused expiry inside
  task automatic t_hand(input logic [7:0] a, input logic [31:0] v);
    int n;
    add = a;
    wr_stage(3'h0, v);
    pulse_timer();
    chk1("istart", 1'b1, istart);
    chk1("oe", 1'b1, p_oe);
    chk1("strong", 1'b0, p_str);
    chk1("out", 1'b1, p_out);
    chk1("busy", 1'b0, busy);
    chk32("target", v, tgt);
    tick(1);
    pulse_timer();
    chk1("istart", 1'b0, istart);
    chk1("strong", 1'b0, p_str);
    n = 0;
    while (p_str !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (n == 50)
    begin
      n_mismatch++;
      end_of_test();
    end
    n = 0;
    while (p_str === 1'b1 && p_out === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    chk32("hold", 32'(a), 32'(n));
    chk1("out", 1'b0, p_out);
    chk1("busy", 1'b1, busy);
    tick(5);
    chk1("strong", 1'b1, p_str);
    chk1("out", 1'b0, p_out);
  endtask : t_hand
  // Plain mode, active low, pin direction followed
  task automatic t_plain;
    busy_en = 1'b0;
    dir = 1'b1;
    pol = 1'b0;
    tick(1);
    chk1("oe", 1'b1, p_oe);
    chk1("busy", 1'b0, busy);
    pulse_timer();
    chk1("istart", 1'b1, istart);
    chk1("out", 1'b0, p_out);
    tick(1);
    chk1("out", 1'b1, p_out);
    dir = 1'b0;
    tick(1);
    chk1("oe", 1'b0, p_oe);
  endtask : t_plain
  // One eight-stage compare pipeline: head loads, then the line advances
  task automatic t_single;
    pen = 4'h2;
    wr_stage(3'h0, 32'h0000_00b0);
    tick(1);
    wr_stage(3'h1, 32'h0000_00b1);
    pulse_timer();
    chk32("compare", 32'h0000_00b0, cmp);
    tick(1);
    pulse_timer();
    chk32("compare", 32'h0000_00b1, cmp);
  endtask : t_single
  // Four two-stage pipes, target cyclic, compare not
  task automatic t_pipes;
    logic [31:0] et [4];
    logic [31:0] ec [4];
    // Target written back is the empty head loaded by the plain start
    et = '{32'h0000_00a0, 32'h0000_00a1, 32'h0000_0000, 32'h0000_00a0};
    ec = '{32'h0000_00a2, 32'h0000_00a3, 32'h0000_00a3, 32'h0000_00a3};
    pen = 4'hf;
    cyc = 4'h1;
    // Idle cycle between strobes so no strobe falls and rises at once
    for (int i = 0; i < 8; i++)
    begin
      wr_stage(3'(i), 32'h0000_00a0 + 32'(i));
      tick(1);
    end
    for (int k = 0; k < 4; k++)
    begin
      pulse_timer();
      chk32("target", et[k], tgt);
      chk32("compare", ec[k], cmp);
      tick(1);
    end
  endtask : t_pipes
  initial
  begin
    tick(10);
    resetn_in = 1'b1;
    tick(1);
    t_reset();
    t_hand(8'h01, 32'h0000_0011);
    t_hand(8'h03, T0);
    t_hand(8'h00, 32'h0000_0022);
    t_plain();
    t_single();
    t_pipes();
    chk32("ratio", 32'h0000_00a5, rat);
    chk32("config", 32'h0000_00a7, cfg);
    end_of_test();
  end
endmodule : masterless_start_sync_tb
